// File: logic/flag_bank_pkg.sv
/*
  Constants, register map and helpers for the interrupt flag status bank.
  Assumes a single 20 MHz clock domain and an AXI4-Lite register bus.
*/
// Behaviour
// - Second I2C master event sets bit 2 of flag_status_three.
// - Second I2C slave event sets bit 1 of flag_status_three.
// - Timer seven request sets bit 0 of flag_status_three.
// - Second CAN transmit request sets bit 7 of flag_status_four.
// - First CAN transmit request sets bit 6 of flag_status_four.
// - DMA channel seven completion sets bit 5 of flag_status_four.
// - DMA channel six completion sets bit 4 of flag_status_four.
// - Second UART error request sets bit 2 of flag_status_four.
// - First UART error request sets bit 1 of flag_status_four.
// - A flag reads one once its source request is recorded.
// - A flag reads zero while no source request is recorded and no software write has stored a one in it.
`default_nettype none
package flag_bank_pkg;

  localparam int REG_W  = 16;
  localparam int ADDR_W = 8;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFF_FLAGS_THREE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FLAGS_FOUR  = 8'h04;

  // Flag positions in flag_status_three
  localparam int POS_I2C_B_MASTER = 2;
  localparam int POS_I2C_B_SLAVE  = 1;
  localparam int POS_TIMER_SEVEN  = 0;

  // Flag positions in flag_status_four
  localparam int POS_CAN_B_TX     = 7;
  localparam int POS_CAN_A_TX     = 6;
  localparam int POS_DMA_SEVEN    = 5;
  localparam int POS_DMA_SIX      = 4;
  localparam int POS_UART_B_ERR   = 2;
  localparam int POS_UART_A_ERR   = 1;
  localparam int POS_PWM_FAULT_B  = 0;

  // Implemented bits and values after reset
  localparam logic [REG_W-1:0] MASK_FLAGS_THREE  = 16'h0007;
  localparam logic [REG_W-1:0] MASK_FLAGS_FOUR   = 16'h00f7;
  localparam logic [REG_W-1:0] RESET_FLAGS_THREE = 16'h0000;
  localparam logic [REG_W-1:0] RESET_FLAGS_FOUR  = 16'h0000;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // One-hot register select: bit 0 three, bit 1 four, zero unmapped
  function automatic logic [1:0] reg_select(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'b00};
    reg_select = 2'b00;
    if (w == OFF_FLAGS_THREE) begin
      reg_select = 2'b01;
    end
    if (w == OFF_FLAGS_FOUR) begin
      reg_select = 2'b10;
    end
  endfunction

  // Low two byte strobes widened to a bit mask
  function automatic logic [REG_W-1:0] strobe_mask(input logic [1:0] s);
    strobe_mask = {{8{s[1]}}, {8{s[0]}}};
  endfunction

endpackage
`default_nettype wire

// File: logic/flag_port_if.sv
/*
  Carrier between the bus logic and one flag register.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface flag_port_if;
  import flag_bank_pkg::*;
  logic             wr_en;
  logic [REG_W-1:0] wdata;
  logic [1:0]       wstrb;
  logic [REG_W-1:0] value;

  modport owner (input wr_en, input wdata, input wstrb, output value);
  modport bus   (output wr_en, output wdata, output wstrb, input value);
  modport view  (input value);
endinterface
`default_nettype wire

// File: logic/flag_register.sv
/*
  One sticky flag register: events set bits, software writes store bits.
  Assumes event inputs are synchronous requests, held high to request.
*/
`timescale 1ns/1ns
`default_nettype none
module flag_register
  import flag_bank_pkg::*;
#(
  parameter logic [REG_W-1:0] IMPL_MASK  = 16'h0000,
  parameter logic [REG_W-1:0] RESET_VAL  = 16'h0000
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Source requests
  input  wire logic [REG_W-1:0] events,
  // Bus side
  flag_port_if.owner            port
);

  logic [REG_W-1:0] flags;
  logic [REG_W-1:0] next_flags;

  always_comb begin
    logic [REG_W-1:0] lanes;
    lanes = strobe_mask(port.wstrb);
    next_flags = flags;
    if (port.wr_en) begin
      next_flags = (flags & ~lanes) | (port.wdata & lanes);
    end
    // Set beats a clear in the same cycle, so no request is lost
    next_flags = (next_flags | events) & IMPL_MASK;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= RESET_VAL;
    end else begin
      flags <= next_flags;
    end
  end

  assign port.value = flags;

endmodule
`default_nettype wire

// File: logic/flag_read_decode.sv
/*
  Read data selection for the two flag registers.
  Assumes an aligned word address; unmapped words read zero with a miss.
*/
`timescale 1ns/1ns
`default_nettype none
module flag_read_decode
  import flag_bank_pkg::*;
(
  // Address
  input  wire logic [ADDR_W-1:0] addr,
  // Register views
  flag_port_if.view              three,
  flag_port_if.view              four,
  // Result
  output      logic [31:0]       data,
  output      logic              hit
);

  always_comb begin
    logic [1:0] sel;
    sel = reg_select(addr);
    data = 32'h0000_0000;
    hit = 1'b1;
    unique case (sel)
      2'b01: data = {16'h0000, three.value & MASK_FLAGS_THREE};
      2'b10: data = {16'h0000, four.value & MASK_FLAGS_FOUR};
      default: hit = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// File: logic/interrupt_flag_status_bank.sv
/*
  Interrupt flag status bank: two flag registers behind an AXI4-Lite slave.
  Assumes request inputs are synchronous to mclk and one master at a time.
*/
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module interrupt_flag_status_bank
  import flag_bank_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,

  // Write address channel
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,

  // Write data channel
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,

  // Write response channel
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,

  // Read address channel
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,

  // Read data channel
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,

  // Requests feeding flag_status_three
  input  wire logic              i2c_b_master_req,
  input  wire logic              i2c_b_slave_req,
  input  wire logic              timer_seven_req,

  // Requests feeding flag_status_four
  input  wire logic              can_b_tx_req,
  input  wire logic              can_a_tx_req,
  input  wire logic              dma_ch_seven_done,
  input  wire logic              dma_ch_six_done,
  input  wire logic              uart_b_error_req,
  input  wire logic              uart_a_error_req,
  input  wire logic              pwm_fault_b_req,

  // Flag values toward the rest of the controller
  output var  logic [REG_W-1:0]  flag_status_three,
  output var  logic [REG_W-1:0]  flag_status_four
);

  typedef enum logic [1:0] {
    W_IDLE = 2'b01,
    W_RESP = 2'b10
  } wr_state_t;

  typedef enum logic [1:0] {
    R_IDLE = 2'b01,
    R_RESP = 2'b10
  } rd_state_t;

  // Write side state
  wr_state_t         wstate;
  wr_state_t         next_wstate;
  logic              aw_held;
  logic              next_aw_held;
  logic [ADDR_W-1:0] awaddr_q;
  logic [ADDR_W-1:0] next_awaddr_q;
  logic              w_held;
  logic              next_w_held;
  logic [REG_W-1:0]  wdata_q;
  logic [REG_W-1:0]  next_wdata_q;
  logic [1:0]        wstrb_q;
  logic [1:0]        next_wstrb_q;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              do_write;
  logic [1:0]        wsel;

  // Read side state
  rd_state_t         rstate;
  rd_state_t         next_rstate;
  logic              next_arready;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic [31:0]       rd_word;
  logic              rd_hit;

  // Event vectors
  logic [REG_W-1:0]  events_three;
  logic [REG_W-1:0]  events_four;

  flag_port_if port_three ();
  flag_port_if port_four ();

  always_comb begin
    events_three = 16'h0000;
    events_three[POS_I2C_B_MASTER] = i2c_b_master_req;
    events_three[POS_I2C_B_SLAVE]  = i2c_b_slave_req;
    events_three[POS_TIMER_SEVEN]  = timer_seven_req;
  end

  always_comb begin
    events_four = 16'h0000;
    events_four[POS_CAN_B_TX]    = can_b_tx_req;
    events_four[POS_CAN_A_TX]    = can_a_tx_req;
    events_four[POS_DMA_SEVEN]   = dma_ch_seven_done;
    events_four[POS_DMA_SIX]     = dma_ch_six_done;
    events_four[POS_UART_B_ERR]  = uart_b_error_req;
    events_four[POS_UART_A_ERR]  = uart_a_error_req;
    events_four[POS_PWM_FAULT_B] = pwm_fault_b_req;
  end

  flag_register #(
    .IMPL_MASK (MASK_FLAGS_THREE),
    .RESET_VAL (RESET_FLAGS_THREE)
  ) u_flags_three (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .events (events_three),
    .port   (port_three)
  );

  flag_register #(
    .IMPL_MASK (MASK_FLAGS_FOUR),
    .RESET_VAL (RESET_FLAGS_FOUR)
  ) u_flags_four (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .events (events_four),
    .port   (port_four)
  );

  flag_read_decode u_read_decode (
    .addr  (s_axi_araddr),
    .three (port_three),
    .four  (port_four),
    .data  (rd_word),
    .hit   (rd_hit)
  );

  // Write strobe reaches a register only when both halves are held
  assign do_write = (wstate == W_IDLE) && aw_held && w_held;
  assign wsel = reg_select(awaddr_q);

  assign port_three.wr_en = do_write && wsel[0];
  assign port_three.wdata = wdata_q;
  assign port_three.wstrb = wstrb_q;
  assign port_four.wr_en  = do_write && wsel[1];
  assign port_four.wdata  = wdata_q;
  assign port_four.wstrb  = wstrb_q;

  // Address and data are caught independently, in either order
  always_comb begin
    next_aw_held  = aw_held;
    next_awaddr_q = awaddr_q;
    next_w_held   = w_held;
    next_wdata_q  = wdata_q;
    next_wstrb_q  = wstrb_q;
    next_wstate   = wstate;
    next_bvalid   = s_axi_bvalid;
    next_bresp    = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held  = 1'b1;
      next_awaddr_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held  = 1'b1;
      next_wdata_q = s_axi_wdata[REG_W-1:0];
      next_wstrb_q = s_axi_wstrb[1:0];
    end
    unique case (wstate)
      W_IDLE: begin
        if (do_write) begin
          next_aw_held = 1'b0;
          next_w_held  = 1'b0;
          next_bvalid  = 1'b1;
          next_bresp   = (wsel != 2'b00) ? RESP_OKAY : RESP_SLVERR;
          next_wstate  = W_RESP;
        end
      end
      W_RESP: begin
        if (s_axi_bready) begin
          next_bvalid = 1'b0;
          next_wstate = W_IDLE;
        end
      end
    endcase
    // Readies drop once a half is held, so a second write waits
    next_awready = (next_wstate == W_IDLE) && !next_aw_held;
    next_wready  = (next_wstate == W_IDLE) && !next_w_held;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wstate        <= W_IDLE;
      aw_held       <= 1'b0;
      awaddr_q      <= 8'h00;
      w_held        <= 1'b0;
      wdata_q       <= 16'h0000;
      wstrb_q       <= 2'b00;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      wstate        <= next_wstate;
      aw_held       <= next_aw_held;
      awaddr_q      <= next_awaddr_q;
      w_held        <= next_w_held;
      wdata_q       <= next_wdata_q;
      wstrb_q       <= next_wstrb_q;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
    end
  end

  // Read data is sampled at the address handshake; later events wait
  always_comb begin
    next_rstate  = rstate;
    next_arready = s_axi_arready;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    unique case (rstate)
      R_IDLE: begin
        if (s_axi_arvalid && s_axi_arready) begin
          next_arready = 1'b0;
          next_rvalid  = 1'b1;
          next_rdata   = rd_word;
          next_rresp   = rd_hit ? RESP_OKAY : RESP_SLVERR;
          next_rstate  = R_RESP;
        end
      end
      R_RESP: begin
        if (s_axi_rready) begin
          next_rvalid  = 1'b0;
          next_arready = 1'b1;
          next_rstate  = R_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstate        <= R_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      rstate        <= next_rstate;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // Copies of the flags so each output leaves a flip-flop of this module
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_status_three <= RESET_FLAGS_THREE;
      flag_status_four  <= RESET_FLAGS_FOUR;
    end else begin
      flag_status_three <= port_three.value;
      flag_status_four  <= port_four.value;
    end
  end

endmodule
`default_nettype wire

// File: verif/flag_bank_sva.sv
/*
  Port assertions for the interrupt flag status bank.
  Assumes one clock, mclk, and rst_n asynchronous and active low.
*/
`timescale 1ns/1ns
`default_nettype none
module flag_bank_sva (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Requests
  input wire logic        i2c_b_master_req,
  input wire logic        i2c_b_slave_req,
  input wire logic        timer_seven_req,
  input wire logic        can_b_tx_req,
  input wire logic        can_a_tx_req,
  input wire logic        dma_ch_seven_done,
  input wire logic        dma_ch_six_done,
  input wire logic        uart_b_error_req,
  input wire logic        uart_a_error_req,
  input wire logic        pwm_fault_b_req,
  // Flag copies
  input wire logic [15:0] flag_status_three,
  input wire logic [15:0] flag_status_four
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Output copy lags the internal flag by one cycle
  property p_set(req, flg);
    req |-> ##2 flg;
  endproperty

  chk_i2c_master_set: assert property (
    p_set(i2c_b_master_req, flag_status_three[2]))
    else $error("i2c master flag not set");
  chk_i2c_slave_set: assert property (
    p_set(i2c_b_slave_req, flag_status_three[1]))
    else $error("i2c slave flag not set");
  chk_timer_set: assert property (
    p_set(timer_seven_req, flag_status_three[0]))
    else $error("timer flag not set");
  chk_can_b_set: assert property (
    p_set(can_b_tx_req, flag_status_four[7]))
    else $error("can b flag not set");
  chk_can_a_set: assert property (
    p_set(can_a_tx_req, flag_status_four[6]))
    else $error("can a flag not set");
  chk_dma_seven_set: assert property (
    p_set(dma_ch_seven_done, flag_status_four[5]))
    else $error("dma seven flag not set");
  chk_dma_six_set: assert property (
    p_set(dma_ch_six_done, flag_status_four[4]))
    else $error("dma six flag not set");
  chk_uart_b_set: assert property (
    p_set(uart_b_error_req, flag_status_four[2]))
    else $error("uart b flag not set");
  chk_uart_a_set: assert property (
    p_set(uart_a_error_req, flag_status_four[1]))
    else $error("uart a flag not set");
  chk_pwm_fault_set: assert property (
    p_set(pwm_fault_b_req, flag_status_four[0]))
    else $error("pwm fault flag not set");
  chk_unused_zero: assert property (
    flag_status_three[15:3] == 13'h0000 && flag_status_four[15:8] == 8'h00
    && !flag_status_four[3])
    else $error("unimplemented bit set");
  chk_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  chk_reset_clear: assert property (
    $rose(rst_n) |-> flag_status_three == 16'h0000
    && flag_status_four == 16'h0000)
    else $error("flags not clear after reset");
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_write_done: assert property (
    s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid ##1 s_axi_awready && s_axi_wready)
    else $error("write not retired");
  chk_read_done: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not retired");

  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'b10);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (timer_seven_req [*3]);
endmodule

bind interrupt_flag_status_bank flag_bank_sva i_sva (
  .mclk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .i2c_b_master_req, .i2c_b_slave_req, .timer_seven_req,
  .can_b_tx_req, .can_a_tx_req, .dma_ch_seven_done, .dma_ch_six_done,
  .uart_b_error_req, .uart_a_error_req, .pwm_fault_b_req,
  .flag_status_three, .flag_status_four
);
`default_nettype wire

// File: verif/event_sources.sv
/*
  Peripheral event sources beside the flag bank.
  Assumes the bench names which sources fire; each request is registered.
*/
`timescale 1ns/1ns
`default_nettype none
module event_sources (
  // Clock
  input  wire logic       mclk,
  // Commands from the bench
  input  wire logic [9:0] fire,
  // Requests toward the bank, synchronous like real peripherals
  output var  logic [9:0] req
);
  always_ff @(posedge mclk) begin
    req <= fire;
  end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
/*
  Self-checking bench for the flag bank over AXI4-Lite.
  Assumes flag_status_three at 0x00 and flag_status_four at 0x04.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import flag_bank_pkg::*;
;
  logic        mclk, rst_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb, wr_lanes;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [9:0]  fire, req;
  logic [15:0] flag_status_three, flag_status_four;
  int          mismatches, num_checks;
  // Source k: bits 0..6 feed the fourth register, 7..9 the third
  localparam int POS [10] = '{POS_PWM_FAULT_B, POS_UART_A_ERR,
    POS_UART_B_ERR, POS_DMA_SIX, POS_DMA_SEVEN, POS_CAN_A_TX, POS_CAN_B_TX,
    POS_TIMER_SEVEN, POS_I2C_B_SLAVE, POS_I2C_B_MASTER};

  always #25 mclk = ~mclk;

  event_sources i_src (.mclk(mclk), .fire(fire), .req(req));

  interrupt_flag_status_bank i_dut (
    .mclk, .rst_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .i2c_b_master_req(req[9]), .i2c_b_slave_req(req[8]),
    .timer_seven_req(req[7]), .can_b_tx_req(req[6]),
    .can_a_tx_req(req[5]), .dma_ch_seven_done(req[4]),
    .dma_ch_six_done(req[3]), .uart_b_error_req(req[2]),
    .uart_a_error_req(req[1]), .pwm_fault_b_req(req[0]),
    .flag_status_three, .flag_status_four
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic timed_out();
    mismatches++;
    $display("wait ran out at %0t", $time);
    stop_test();
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    bit aw;
    bit w;
    int n;
    aw = 0;
    w = 0;
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= wr_lanes;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 50) timed_out();
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    bit ar;
    int n;
    ar = 0;
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (!ar && s_axi_arready) begin
        ar = 1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 50) timed_out();
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    check({16'h0000, flag_status_three}, 32'h0);
    check({16'h0000, flag_status_four}, 32'h0);
    axi_read(OFF_FLAGS_THREE, d, r);
    check(d, 32'h0);
    axi_read(OFF_FLAGS_FOUR, d, r);
    check(d, 32'h0);
    $display("reset values done");
  endtask

  // One source at a time, so a crossed wire shows as a wrong bit
  task automatic t_sources();
    logic [31:0] d;
    logic [31:0] exp;
    logic [31:0] seen;
    logic [7:0]  a;
    logic [1:0]  r;
    for (int k = 0; k < 10; k++) begin
      a = (k < 7) ? OFF_FLAGS_FOUR : OFF_FLAGS_THREE;
      exp = 32'h1 << POS[k];
      @(posedge mclk);
      fire <= 10'h001 << k;
      @(posedge mclk);
      fire <= 10'h000;
      axi_read(a, d, r);
      check(d, exp); // to
      check({30'h0, r}, 32'h0);
      seen = {16'h0000, (k < 7) ? flag_status_four : flag_status_three};
      check(seen, exp);
      axi_write(a, 32'h0, r);
      axi_read(a, d, r);
      check(d, 32'h0);
    end
    $display("event sources done");
  endtask

  task automatic t_writable();
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(OFF_FLAGS_FOUR, 32'hffff_ffff, r);
    check({30'h0, r}, 32'h0);
    axi_read(OFF_FLAGS_FOUR, d, r);
    check(d, 32'h0000_00f7);
    axi_write(OFF_FLAGS_THREE, 32'hffff_ffff, r);
    axi_read(OFF_FLAGS_THREE, d, r);
    check(d, 32'h0000_0007);
    axi_write(OFF_FLAGS_FOUR, 32'h0, r);
    axi_write(OFF_FLAGS_THREE, 32'h0, r);
    axi_read(OFF_FLAGS_FOUR, d, r);
    check(d, 32'h0);
    // Upper lane only: the low flags must not move
    wr_lanes = 4'h2;
    axi_write(OFF_FLAGS_FOUR, 32'hffff_ffff, r);
    axi_read(OFF_FLAGS_FOUR, d, r);
    check(d, 32'h0);
    wr_lanes = 4'h1;
    axi_write(OFF_FLAGS_FOUR, 32'hffff_ffff, r);
    axi_read(OFF_FLAGS_FOUR, d, r);
    check(d, 32'h0000_00f7);
    wr_lanes = 4'hf;
    axi_write(OFF_FLAGS_FOUR, 32'h0, r);
    $display("software write done");
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(8'h08, 32'hffff_ffff, r);
    check({30'h0, r}, 32'h2);
    axi_read(8'h08, d, r);
    check(d, 32'h0);
    check({30'h0, r}, 32'h2);
    axi_read(OFF_FLAGS_FOUR, d, r);
    check(d, 32'h0);
    $display("unmapped access done");
  endtask

  // A held request must survive a clearing write
  task automatic t_set_wins();
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge mclk);
    fire <= 10'h080;
    axi_write(OFF_FLAGS_THREE, 32'h0, r);
    axi_read(OFF_FLAGS_THREE, d, r);
    check(d, 32'h1);
    fire <= 10'h000;
    axi_write(OFF_FLAGS_THREE, 32'h0, r);
    axi_read(OFF_FLAGS_THREE, d, r);
    check(d, 32'h0);
    $display("set over clear done");
  endtask

  // A reset in mid-run must drop a recorded flag
  task automatic t_mid_reset();
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge mclk);
    fire <= 10'h040;
    @(posedge mclk);
    fire <= 10'h000;
    repeat (3) @(posedge mclk);
    check({16'h0000, flag_status_four}, 32'h0000_0080);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check({16'h0000, flag_status_four}, 32'h0);
    axi_read(OFF_FLAGS_FOUR, d, r);
    check(d, 32'h0);
    $display("mid-run reset done");
  endtask

  initial begin
    mclk          = 1'b0;
    rst_n         = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_araddr  = 8'h00;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'hf;
    wr_lanes      = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    fire          = 10'h000;
    mismatches    = 0;
    num_checks    = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_sources();
    t_writable();
    t_unmapped();
    t_set_wins();
    t_mid_reset();
    stop_test();
  end
endmodule
`default_nettype wire
